// file: include/ntw_pkg.sv
// Constants for the tag wake and pad control block.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.
package ntw_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam int         ADDR_W        = 8;
	localparam logic [7:0] OFF_PAD_CTRL  = 8'h00;
	localparam logic [7:0] OFF_SUPPLY    = 8'h04;
	localparam logic [7:0] OFF_SLEEP_WK  = 8'h08;
	localparam logic [7:0] OFF_DEEP_SRC  = 8'h0c;
	localparam logic [7:0] OFF_WAKE_CTRL = 8'h10;
	localparam logic [7:0] OFF_CAUSE     = 8'h14;
	localparam logic [7:0] OFF_STATUS    = 8'h18;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PC_SUP_PD  = 0;
	localparam int PC_SUP_PUN = 1;
	localparam int PC_SUP_HS0 = 2;
	localparam int PC_SUP_HS1 = 3;
	localparam int PC_SUP_OD  = 4;
	localparam int PC_BUS_PD  = 8;
	localparam int PC_BUS_PUN = 9;
	localparam int PC_BUS_HS0 = 10;
	localparam int PC_BUS_INV = 11;
	localparam int PC_BUS_RXE = 12;
	localparam int PC_BUS_FOF = 13;
	localparam int PC_BUS_HS1 = 14;
	localparam int PC_BUS_OD  = 15;
	localparam int PC_INT_INV = 16;
	localparam int SUP_VAL    = 0;
	localparam int SUP_OE     = 1;
	localparam int SW_TAG     = 0;
	localparam int DS_TAG     = 0;
	localparam int WC_TAG_RST = 0;
	localparam int WC_IO_RST  = 1;
	localparam int WC_FALL    = 2;
	localparam int CS_TAG     = 0;
	localparam int CS_IO      = 1;
	localparam int ST_FD      = 0;
	localparam int ST_INT_LVL = 1;
	// ----------------------------------------
	// Writable masks and reset values
	// ----------------------------------------
	localparam logic [31:0] PAD_CTRL_MASK = 32'h0001_ff1f;
	localparam logic [31:0] SUPPLY_MASK   = 32'h0000_0003;
	localparam logic [31:0] ONE_BIT_MASK  = 32'h0000_0001;
	localparam logic [31:0] WAKE_CTRL_MSK = 32'h0000_0007;
	localparam logic [31:0] CAUSE_MASK    = 32'h0000_0003;
	localparam logic [31:0] REG_RST       = 32'h0000_0000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int FILT_TIME_NS  = 50;
	localparam int FILT_CYC      = (FILT_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int SYNC_STAGES   = 2;
endpackage : ntw_pkg

// file: include/ntw_pad_if.sv
// Interface between the control logic and one two-wire bus pad.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface ntw_pad_if;
	logic rx_en;
	logic in_pol;
	logic filt_byp;
	logic open_drain;
	logic ctl_out;
	logic pad_in;
	logic ctl_in;
	logic pad_out;
	logic pad_oe_n;
	modport ctrl (
		output rx_en, in_pol, filt_byp, open_drain, ctl_out, pad_in,
		input  ctl_in, pad_out, pad_oe_n
	);
	modport pad (
		input  rx_en, in_pol, filt_byp, open_drain, ctl_out, pad_in,
		output ctl_in, pad_out, pad_oe_n
	);
endinterface : ntw_pad_if
`default_nettype wire

// file: hw/ntw_sync.sv
// Level synchroniser for the asynchronous field-detect input.
// Assumes only the last stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module ntw_sync #(
	parameter int STAGES = 2
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic [STAGES-1:0] chain_ff;
	logic [STAGES-1:0] nxt_chain;

	always_comb begin
		nxt_chain = {chain_ff[STAGES-2:0], async_i};
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			chain_ff <= '0;
		end else begin
			chain_ff <= nxt_chain;
		end
	end

	assign sync_o = chain_ff[STAGES-1];

	property p_sync_delay;
		@(posedge clk_i) disable iff (!rst_n_i)
		##2 (sync_o == $past(async_i, 2));
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("sync output not two cycles behind input");
endmodule : ntw_sync
`default_nettype wire

// file: hw/ntw_bus_pad.sv
// One two-wire bus pad: input polarity, receiver, glitch filter, drive.
// Assumes the pad input is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module ntw_bus_pad #(
	parameter int FILT_N = 10
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	ntw_pad_if.pad    p
);
	logic [$clog2(FILT_N+1)-1:0] cnt_ff, nxt_cnt;
	logic cand_ff, nxt_cand;
	logic filt_ff, nxt_filt;
	logic in_ff, nxt_in;
	logic out_ff, nxt_out;
	logic oe_n_ff, nxt_oe_n;
	logic raw;

	always_comb begin
		raw = p.rx_en ? (p.pad_in ^ p.in_pol) : 1'b0;
		nxt_cand = cand_ff;
		nxt_cnt  = cnt_ff;
		nxt_filt = filt_ff;
		if (raw != cand_ff) begin
			nxt_cand = raw;
			nxt_cnt  = '0;
		end else if (int'(cnt_ff) == FILT_N - 1) begin
			nxt_filt = cand_ff;
		end else begin
			nxt_cnt = cnt_ff + 1'b1;
		end
		nxt_in = p.filt_byp ? raw : filt_ff;
		if (p.open_drain) begin
			nxt_out  = 1'b0;
			nxt_oe_n = p.ctl_out;
		end else begin
			nxt_out  = p.ctl_out;
			nxt_oe_n = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_ff  <= '0;
			cand_ff <= 1'b0;
			filt_ff <= 1'b0;
			in_ff   <= 1'b0;
			out_ff  <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			cnt_ff  <= nxt_cnt;
			cand_ff <= nxt_cand;
			filt_ff <= nxt_filt;
			in_ff   <= nxt_in;
			out_ff  <= nxt_out;
			oe_n_ff <= nxt_oe_n;
		end
	end

	assign p.ctl_in   = in_ff;
	assign p.pad_out  = out_ff;
	assign p.pad_oe_n = oe_n_ff;

	property p_od_never_high;
		@(posedge clk_i) disable iff (!rst_n_i)
		$past(p.open_drain) |-> !(p.pad_out && !p.pad_oe_n);
	endproperty
	a_od_never_high: assert property (p_od_never_high)
		else $error("open-drain pad drove high");

	property p_bypass;
		@(posedge clk_i) disable iff (!rst_n_i)
		$past(p.filt_byp) |->
			p.ctl_in == ($past(p.rx_en) & ($past(p.pad_in) ^ $past(p.in_pol)));
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("unfiltered input path wrong");

	property p_glitch;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!p.filt_byp && $stable(raw) && $changed(filt_ff)) |->
			$past(raw) == filt_ff;
	endproperty
	a_glitch: assert property (p_glitch)
		else $error("filter output took unstable value");
endmodule : ntw_bus_pad
`default_nettype wire

// file: hw/ntw_top.sv
// Tag wake and pad control: APB registers, tag supply pad, two bus
// pads, field-detect wake and interrupt.
// Assumes APB master, 200 MHz clock, field-detect asynchronous.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ntw_top import ntw_pkg::*; #(
	parameter int SYNC_N = SYNC_STAGES,
	parameter int FILT_N = FILT_CYC
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Tag and power management
	input  wire logic              field_present_out_i,
	input  wire logic              in_deep_sleep_i,
	input  wire logic              in_power_down_i,
	input  wire logic              in_deep_pd_i,
	input  wire logic              io_wake_i,
	output logic                   wake_o,
	output logic                   tag_irq_o,
	// Tag supply pad
	output logic                   supply_pad_o,
	output logic                   supply_pad_oe_n_o,
	output logic                   supply_pad_pulldown_en_o,
	output logic                   supply_pad_pullup_en_n_o,
	output logic      [1:0]        supply_pad_slew_o,
	output logic                   supply_pad_pseudo_od_o,
	// Bus pads
	input  wire logic              scl_pad_i,
	output logic                   scl_pad_o,
	output logic                   scl_pad_oe_n_o,
	input  wire logic              sda_pad_i,
	output logic                   sda_pad_o,
	output logic                   sda_pad_oe_n_o,
	output logic                   bus_pad_pulldown_en_o,
	output logic                   bus_pad_pullup_en_n_o,
	output logic      [1:0]        bus_pad_slew_o,
	// Bus controller side
	input  wire logic              ctl_scl_i,
	input  wire logic              ctl_sda_i,
	output logic                   ctl_scl_o,
	output logic                   ctl_sda_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [31:0] pad_ctrl_ff, nxt_pad_ctrl;
	logic [31:0] supply_ff, nxt_supply;
	logic [31:0] sleep_wk_ff, nxt_sleep_wk;
	logic [31:0] deep_src_ff, nxt_deep_src;
	logic [31:0] wake_ctrl_ff, nxt_wake_ctrl;
	logic [31:0] cause_ff, nxt_cause;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        pready_ff, nxt_pready;
	logic        pslverr_ff, nxt_pslverr;
	logic        fd_prev_ff, nxt_fd_prev;
	logic        int_prev_ff, nxt_int_prev;
	logic        irq_ff, nxt_irq;
	logic        wake_ff, nxt_wake;
	logic [9:0]  pin_ff, nxt_pin;
	logic        fd_sync, int_lvl, fd_edge, acc_wr, setup;
	logic        wk_ds, wk_pd, wk_dpd, wk_io, fd_wake;
	logic [31:0] rd_data;

	ntw_pad_if scl_if ();
	ntw_pad_if sda_if ();

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_PAD_CTRL, OFF_SUPPLY, OFF_SLEEP_WK, OFF_DEEP_SRC,
			OFF_WAKE_CTRL, OFF_CAUSE, OFF_STATUS: reg_hit = 1'b1;
			default: reg_hit = 1'b0;
		endcase
	endfunction : reg_hit

	function automatic logic [31:0] wr_field(input logic [31:0] old,
		input logic [31:0] wd, input logic [31:0] msk);
		wr_field = (old & ~msk) | (wd & msk);
	endfunction : wr_field

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	ntw_sync #(.STAGES(SYNC_N)) u_fd_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i (field_present_out_i),
		.sync_o  (fd_sync)
	);

	ntw_bus_pad #(.FILT_N(FILT_N)) u_scl (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.p       (scl_if.pad)
	);

	ntw_bus_pad #(.FILT_N(FILT_N)) u_sda (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.p       (sda_if.pad)
	);

	// Shared pad configuration, separate data
	assign scl_if.rx_en      = pad_ctrl_ff[PC_BUS_RXE];
	assign scl_if.in_pol     = pad_ctrl_ff[PC_BUS_INV];
	assign scl_if.filt_byp   = pad_ctrl_ff[PC_BUS_FOF];
	assign scl_if.open_drain = pad_ctrl_ff[PC_BUS_OD];
	assign scl_if.ctl_out    = ctl_scl_i;
	assign scl_if.pad_in     = scl_pad_i;
	assign sda_if.rx_en      = pad_ctrl_ff[PC_BUS_RXE];
	assign sda_if.in_pol     = pad_ctrl_ff[PC_BUS_INV];
	assign sda_if.filt_byp   = pad_ctrl_ff[PC_BUS_FOF];
	assign sda_if.open_drain = pad_ctrl_ff[PC_BUS_OD];
	assign sda_if.ctl_out    = ctl_sda_i;
	assign sda_if.pad_in     = sda_pad_i;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		setup  = psel_i && !penable_i;
		acc_wr = psel_i && penable_i && pwrite_i && pready_ff
			&& !pslverr_ff;
		case (paddr_i)
			OFF_PAD_CTRL:  rd_data = pad_ctrl_ff;
			OFF_SUPPLY:    rd_data = supply_ff;
			OFF_SLEEP_WK:  rd_data = sleep_wk_ff;
			OFF_DEEP_SRC:  rd_data = deep_src_ff;
			OFF_WAKE_CTRL: rd_data = wake_ctrl_ff;
			OFF_CAUSE:     rd_data = cause_ff;
			OFF_STATUS: begin
				rd_data             = REG_RST;
				rd_data[ST_FD]      = fd_sync;
				rd_data[ST_INT_LVL] = int_lvl;
			end
			default:       rd_data = REG_RST;
		endcase
		nxt_pready  = setup;
		nxt_pslverr = setup && !reg_hit(paddr_i);
		nxt_prdata  = setup ? rd_data : prdata_ff;

		nxt_pad_ctrl  = pad_ctrl_ff;
		nxt_supply    = supply_ff;
		nxt_sleep_wk  = sleep_wk_ff;
		nxt_deep_src  = deep_src_ff;
		nxt_wake_ctrl = wake_ctrl_ff;
		nxt_cause     = cause_ff;
		if (acc_wr) begin
			case (paddr_i)
				OFF_PAD_CTRL: nxt_pad_ctrl =
					wr_field(pad_ctrl_ff, pwdata_i, PAD_CTRL_MASK);
				OFF_SUPPLY: nxt_supply =
					wr_field(supply_ff, pwdata_i, SUPPLY_MASK);
				OFF_SLEEP_WK: nxt_sleep_wk =
					wr_field(sleep_wk_ff, pwdata_i, ONE_BIT_MASK);
				OFF_DEEP_SRC: nxt_deep_src =
					wr_field(deep_src_ff, pwdata_i, ONE_BIT_MASK);
				OFF_WAKE_CTRL: nxt_wake_ctrl =
					wr_field(wake_ctrl_ff, pwdata_i, WAKE_CTRL_MSK);
				OFF_CAUSE: nxt_cause =
					cause_ff & ~(pwdata_i & CAUSE_MASK);
				default: nxt_cause = cause_ff;
			endcase
		end

		// Wake on the selected field-detect edge, or on the IO wake level
		nxt_fd_prev = fd_sync;
		fd_edge = wake_ctrl_ff[WC_FALL] ? (fd_prev_ff && !fd_sync)
			: (!fd_prev_ff && fd_sync);
		wk_ds  = in_deep_sleep_i && sleep_wk_ff[SW_TAG] && fd_edge;
		wk_pd  = in_power_down_i && deep_src_ff[DS_TAG] && fd_edge;
		wk_dpd = in_deep_pd_i && deep_src_ff[DS_TAG] && fd_edge
			&& (wake_ctrl_ff[WC_TAG_RST] || wake_ctrl_ff[WC_IO_RST]);
		wk_io  = in_deep_pd_i && wake_ctrl_ff[WC_IO_RST] && io_wake_i;
		fd_wake  = wk_ds || wk_pd || wk_dpd;
		nxt_wake = fd_wake || wk_io;
		// Set wins over a same-cycle clear
		if (fd_wake) begin
			nxt_cause[CS_TAG] = 1'b1;
		end
		if (wk_io) begin
			nxt_cause[CS_IO] = 1'b1;
		end

		// Interrupt on rising edge of possibly inverted level
		int_lvl      = fd_sync ^ pad_ctrl_ff[PC_INT_INV];
		nxt_int_prev = int_lvl;
		nxt_irq      = int_lvl && !int_prev_ff;

		// Pad pins held from registers, independent of power state
		nxt_pin[0] = supply_ff[SUP_VAL] && supply_ff[SUP_OE];
		nxt_pin[1] = !supply_ff[SUP_OE];
		nxt_pin[2] = pad_ctrl_ff[PC_SUP_PD];
		nxt_pin[3] = pad_ctrl_ff[PC_SUP_PUN];
		nxt_pin[4] = pad_ctrl_ff[PC_SUP_HS0];
		nxt_pin[5] = pad_ctrl_ff[PC_SUP_HS1];
		nxt_pin[6] = pad_ctrl_ff[PC_SUP_OD];
		nxt_pin[7] = pad_ctrl_ff[PC_BUS_PD];
		nxt_pin[8] = pad_ctrl_ff[PC_BUS_PUN];
		nxt_pin[9] = 1'b0;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [1:0] bus_slew_ff;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pad_ctrl_ff  <= REG_RST;
			supply_ff    <= REG_RST;
			sleep_wk_ff  <= REG_RST;
			deep_src_ff  <= REG_RST;
			wake_ctrl_ff <= REG_RST;
			cause_ff     <= REG_RST;
			prdata_ff    <= REG_RST;
			pready_ff    <= 1'b0;
			pslverr_ff   <= 1'b0;
			fd_prev_ff   <= 1'b0;
			int_prev_ff  <= 1'b0;
			irq_ff       <= 1'b0;
			wake_ff      <= 1'b0;
			pin_ff       <= 10'h002;
			bus_slew_ff  <= 2'h0;
		end else begin
			pad_ctrl_ff  <= nxt_pad_ctrl;
			supply_ff    <= nxt_supply;
			sleep_wk_ff  <= nxt_sleep_wk;
			deep_src_ff  <= nxt_deep_src;
			wake_ctrl_ff <= nxt_wake_ctrl;
			cause_ff     <= nxt_cause;
			prdata_ff    <= nxt_prdata;
			pready_ff    <= nxt_pready;
			pslverr_ff   <= nxt_pslverr;
			fd_prev_ff   <= nxt_fd_prev;
			int_prev_ff  <= nxt_int_prev;
			irq_ff       <= nxt_irq;
			wake_ff      <= nxt_wake;
			pin_ff       <= nxt_pin;
			bus_slew_ff  <= {pad_ctrl_ff[PC_BUS_HS1],
				pad_ctrl_ff[PC_BUS_HS0]};
		end
	end

	assign prdata_o                 = prdata_ff;
	assign pready_o                 = pready_ff;
	assign pslverr_o                = pslverr_ff;
	assign wake_o                   = wake_ff;
	assign tag_irq_o                = irq_ff;
	assign supply_pad_o             = pin_ff[0];
	assign supply_pad_oe_n_o        = pin_ff[1];
	assign supply_pad_pulldown_en_o = pin_ff[2];
	assign supply_pad_pullup_en_n_o = pin_ff[3];
	assign supply_pad_slew_o        = pin_ff[5:4];
	assign supply_pad_pseudo_od_o   = pin_ff[6];
	assign bus_pad_pulldown_en_o    = pin_ff[7];
	assign bus_pad_pullup_en_n_o    = pin_ff[8];
	assign bus_pad_slew_o           = bus_slew_ff;
	assign scl_pad_o                = scl_if.pad_out;
	assign scl_pad_oe_n_o           = scl_if.pad_oe_n;
	assign sda_pad_o                = sda_if.pad_out;
	assign sda_pad_oe_n_o           = sda_if.pad_oe_n;
	assign ctl_scl_o                = scl_if.ctl_in;
	assign ctl_sda_o                = sda_if.ctl_in;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_int_rise;
		!int_lvl ##1 int_lvl;
	endsequence
	property p_irq_rise;
		s_int_rise |=> tag_irq_o;
	endproperty
	a_irq_rise: assert property (p_irq_rise)
		else $error("no interrupt after rising edge");

	property p_irq_cause;
		tag_irq_o |-> $past(int_lvl) && !$past(int_lvl, 2);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without rising edge");

	property p_wake_ds;
		(wake_o && $past(in_deep_sleep_i) && !$past(in_power_down_i)
			&& !$past(in_deep_pd_i)) |-> $past(sleep_wk_ff[SW_TAG]);
	endproperty
	a_wake_ds: assert property (p_wake_ds)
		else $error("deep-sleep wake without enable");

	property p_wake_pd;
		(wake_o && $past(in_power_down_i) && !$past(in_deep_pd_i)
			&& !$past(in_deep_sleep_i)) |-> $past(deep_src_ff[DS_TAG]);
	endproperty
	a_wake_pd: assert property (p_wake_pd)
		else $error("power-down wake without source bit");

	property p_wake_dpd;
		(wake_o && $past(in_deep_pd_i) && !$past(in_power_down_i)
			&& !$past(in_deep_sleep_i)) |->
			$past(wake_ctrl_ff[WC_TAG_RST]) || $past(wake_ctrl_ff[WC_IO_RST]);
	endproperty
	a_wake_dpd: assert property (p_wake_dpd)
		else $error("deep power-down wake without reset enable");

	property p_io_wake;
		(in_deep_pd_i && wake_ctrl_ff[WC_IO_RST] && io_wake_i)
			|=> wake_o && cause_ff[CS_IO];
	endproperty
	a_io_wake: assert property (p_io_wake)
		else $error("IO wake not taken");

	property p_cause_set;
		fd_wake |=> cause_ff[CS_TAG] && wake_o;
	endproperty
	a_cause_set: assert property (p_cause_set)
		else $error("field wake cause not recorded");

	property p_supply_drive;
		##1 (!supply_pad_oe_n_o == $past(supply_ff[SUP_OE]))
			&& (!supply_pad_o || !supply_pad_oe_n_o);
	endproperty
	a_supply_drive: assert property (p_supply_drive)
		else $error("supply pad drive disagrees with enable");

	property p_supply_hold;
		(in_power_down_i && !acc_wr) [*3] |-> $stable(supply_pad_o)
			&& $stable(supply_pad_oe_n_o);
	endproperty
	a_supply_hold: assert property (p_supply_hold)
		else $error("tag supply changed in power-down");

	property p_bus_pulls;
		##1 bus_pad_pulldown_en_o == $past(pad_ctrl_ff[PC_BUS_PD])
			&& bus_pad_pullup_en_n_o == $past(pad_ctrl_ff[PC_BUS_PUN]);
	endproperty
	a_bus_pulls: assert property (p_bus_pulls)
		else $error("bus pad pull controls wrong");
endmodule : ntw_top
`default_nettype wire

// file: sim/ntw_tag_model.sv
// Behavioural tag chip: field-detect output and two bus lines.
// Assumes pull-ups on both bus lines; tag may pull the data line low.
`timescale 1ns/1ps
`default_nettype none
module ntw_tag_model (
	// Antenna side
	input  wire logic field_near_i,
	// Bus lines from the pads
	input  wire logic scl_drv_i,
	input  wire logic scl_oe_n_i,
	input  wire logic sda_drv_i,
	input  wire logic sda_oe_n_i,
	input  wire logic tag_sda_low_i,
	// To the pads and the core
	output logic      fd_o,
	output logic      scl_o,
	output logic      sda_o
);
	// Field detect follows the field, off the clock grid
	assign #3 fd_o = field_near_i;
	// Pulled-up lines, low only when someone drives low
	assign scl_o = !(!scl_oe_n_i && !scl_drv_i);
	assign sda_o = !((!sda_oe_n_i && !sda_drv_i) || tag_sda_low_i);
endmodule : ntw_tag_model
`default_nettype wire

// file: sim/tb_ntw_top.sv
// Self-checking bench for the tag wake and pad control block.
// Assumes ntw_pkg, the tag model, and an APB master driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_ntw_top import ntw_pkg::*; ;
	localparam int FN = 2;
	logic              clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
	logic              pready_o, pslverr_o, field_near, tag_low;
	logic [ADDR_W-1:0] paddr_i;
	logic [31:0]       pwdata_i, prdata_o;
	logic [31:0]       msk [5];
	logic              field_present_out_i, in_deep_sleep_i, wake_o;
	logic              in_power_down_i, in_deep_pd_i, io_wake_i, tag_irq_o;
	logic              supply_pad_o, supply_pad_oe_n_o, supply_pad_pseudo_od_o;
	logic              supply_pad_pulldown_en_o, supply_pad_pullup_en_n_o;
	logic [1:0]        supply_pad_slew_o, bus_pad_slew_o;
	logic              scl_pad_i, scl_pad_o, scl_pad_oe_n_o;
	logic              sda_pad_i, sda_pad_o, sda_pad_oe_n_o;
	logic              bus_pad_pulldown_en_o, bus_pad_pullup_en_n_o;
	logic              ctl_scl_i, ctl_sda_i, ctl_scl_o, ctl_sda_o;
	logic [7:0]        irq_cnt, wake_cnt, w0;
	int                fail_count, check_count, cyc;

	ntw_top #(.SYNC_N(2), .FILT_N(FN)) u_dut (.clk_i, .rst_n_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .field_present_out_i, .in_deep_sleep_i, .in_power_down_i,
		.in_deep_pd_i, .io_wake_i, .wake_o, .tag_irq_o, .supply_pad_o,
		.supply_pad_oe_n_o, .supply_pad_pulldown_en_o,
		.supply_pad_pullup_en_n_o, .supply_pad_slew_o, .supply_pad_pseudo_od_o,
		.scl_pad_i, .scl_pad_o, .scl_pad_oe_n_o, .sda_pad_i, .sda_pad_o,
		.sda_pad_oe_n_o, .bus_pad_pulldown_en_o, .bus_pad_pullup_en_n_o,
		.bus_pad_slew_o, .ctl_scl_i, .ctl_sda_i, .ctl_scl_o, .ctl_sda_o);
	ntw_tag_model u_tag (.field_near_i(field_near), .scl_drv_i(scl_pad_o),
		.scl_oe_n_i(scl_pad_oe_n_o), .sda_drv_i(sda_pad_o),
		.sda_oe_n_i(sda_pad_oe_n_o), .tag_sda_low_i(tag_low),
		.fd_o(field_present_out_i), .scl_o(scl_pad_i), .sda_o(sda_pad_i));

	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Pulse counters and hang limit
	always @(posedge clk_i) begin
		irq_cnt  <= irq_cnt + 8'(tag_irq_o === 1'b1);
		wake_cnt <= wake_cnt + 8'(wake_o === 1'b1);
		cyc++;
		if (cyc > 5000) begin
			fail_count++;
			report_and_stop;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic report_and_stop;
		if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_i    <= 1;
		penable_i <= 0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i    <= 0;
		penable_i <= 0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(0, a, 0, r, e);
		chk(r, x);
		chk(32'(e), 0);
	endtask : rd
	task automatic pad(input logic [31:0] v);
		wr(OFF_PAD_CTRL, v);
		repeat (3) @(posedge clk_i);
		chk({supply_pad_pseudo_od_o, supply_pad_slew_o,
			supply_pad_pullup_en_n_o, supply_pad_pulldown_en_o}, v[4:0]);
		chk({bus_pad_slew_o, bus_pad_pullup_en_n_o, bus_pad_pulldown_en_o},
			{v[14], v[10], v[9:8]});
	endtask : pad
	task automatic bus(input logic cs, tl, input logic [2:0] e);
		ctl_scl_i <= cs;
		tag_low   <= tl;
		repeat (8) @(posedge clk_i);
		chk({scl_pad_oe_n_o, ctl_scl_o, ctl_sda_o}, e);
	endtask : bus
	task automatic fld(input logic v, input logic [7:0] ei, ew);
		logic [7:0] i0;
		i0 = irq_cnt;
		w0 = wake_cnt;
		field_near <= v;
		repeat (2) @(posedge clk_i);
		chk(irq_cnt - i0, 0);
		repeat (10) @(posedge clk_i);
		chk(irq_cnt - i0, ei);
		chk(wake_cnt - w0, ew);
	endtask : fld
	task automatic io(input logic [31:0] ctl, input logic x);
		wr(OFF_WAKE_CTRL, ctl);
		w0 = wake_cnt;
		io_wake_i <= 1;
		repeat (8) @(posedge clk_i);
		io_wake_i <= 0;
		chk(32'(wake_cnt != w0), 32'(x));
	endtask : io
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic        e;
		{rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{field_near, in_deep_sleep_i, in_power_down_i, in_deep_pd_i} = '0;
		{io_wake_i, ctl_scl_i, ctl_sda_i, tag_low} = '0;
		{irq_cnt, wake_cnt, fail_count, check_count, cyc} = '0;
		msk = '{PAD_CTRL_MASK, SUPPLY_MASK, ONE_BIT_MASK, ONE_BIT_MASK,
			WAKE_CTRL_MSK};
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), REG_RST);
		for (int i = 0; i < 5; i++) begin
			wr(8'(4 * i), '1);
			rd(8'(4 * i), msk[i]);
			wr(8'(4 * i), 0);
		end
		wr(OFF_STATUS, '1);
		rd(OFF_STATUS, 0);
		apb(1, 8'h1c, '1, r, e);
		chk(32'(e), 1);
		apb(0, 8'h1c, 0, r, e);
		chk({r[30:0], e}, 1);
		for (int i = 0; i < 4; i++) begin
			wr(OFF_SUPPLY, 32'(i));
			repeat (3) @(posedge clk_i);
			chk({supply_pad_o, supply_pad_oe_n_o}, {i == 3, i < 2});
		end
		ctl_sda_i <= 1;
		pad(32'hb00c);
		bus(1, 0, 3'b111);
		bus(0, 0, 3'b001);
		bus(1, 1, 3'b110);
		pad(32'hb80c);
		bus(1, 1, 3'b101);
		pad(32'ha00c);
		bus(1, 0, 3'b100);
		pad(32'h300c);
		bus(1, 0, 3'b011);
		chk({scl_pad_o, sda_pad_o, scl_pad_oe_n_o, sda_pad_oe_n_o}, 4'hc);
		pad(32'h900c);
		bus(1, 0, 3'b111);
		tag_low <= 1;
		@(posedge clk_i);
		tag_low <= 0;
		repeat (6) begin
			@(posedge clk_i);
			chk(32'(ctl_sda_o), 1);
		end
		bus(1, 1, 3'b110);
		pad(32'h1000c);
		fld(1, 0, 0);
		fld(0, 1, 0);
		rd(OFF_STATUS, 2);
		pad(32'h000c);
		fld(1, 1, 0);
		fld(0, 0, 0);
		in_deep_sleep_i <= 1;
		fld(1, 1, 0);
		fld(0, 0, 0);
		wr(OFF_SLEEP_WK, 1);
		fld(1, 1, 1);
		rd(OFF_CAUSE, 1);
		wr(OFF_CAUSE, 1);
		rd(OFF_CAUSE, 0);
		fld(0, 0, 0);
		wr(OFF_WAKE_CTRL, 4);
		fld(1, 1, 0);
		fld(0, 0, 1);
		wr(OFF_WAKE_CTRL, 0);
		in_deep_sleep_i <= 0;
		in_power_down_i <= 1;
		fld(1, 1, 0);
		fld(0, 0, 0);
		wr(OFF_DEEP_SRC, 1);
		fld(1, 1, 1);
		fld(0, 0, 0);
		in_power_down_i <= 0;
		in_deep_pd_i    <= 1;
		for (int i = 0; i < 3; i++) begin
			wr(OFF_WAKE_CTRL, 32'(i));
			fld(1, 1, 8'(i > 0));
			fld(0, 0, 0);
		end
		wr(OFF_CAUSE, 3);
		io(2, 1);
		rd(OFF_CAUSE, 2);
		io(1, 0);
		report_and_stop;
	end
endmodule : tb_ntw_top
`default_nettype wire
